// >>> inc/dct_pkg.sv
// Package for the data port clock timing control block.
// Holds the register address, field positions, reset value and the
// delay figures that the analog delay cells are built around.
package dct_pkg;

   // Control port addressing and register reset value.
   localparam logic [7:0]  ADDR_DATA_PORT_CLOCK_TIMING = 8'h02;
   localparam logic [15:0] RESET_DATA_PORT_CLOCK_TIMING = 16'h0004;

   // Field positions inside data_port_clock_timing.
   localparam int DLY_MSB     = 15;
   localparam int DLY_LSB     = 11;
   localparam int MARGIN_MSB  = 10;
   localparam int MARGIN_LSB  = 7;
   localparam int LVDS_SEL    = 6;
   localparam int INVERT      = 5;
   localparam int DLY_EN      = 4;
   localparam int AUTO_MODE   = 3;
   localparam int SET_HIGH    = 2;
   localparam int POLARITY    = 1;
   localparam int RESERVED    = 0;

   // Interpolation codes that allow slave mode.
   localparam logic [1:0] INTERP_4X = 2'h2;
   localparam logic [1:0] INTERP_8X = 2'h3;

   // Delay cell figures, in picoseconds, for the analog side.
   localparam int DLY_MIN_PS    = 700;
   localparam int DLY_MAX_PS    = 6500;
   localparam int DLY_STEP_PS   = 190;
   localparam int MARGIN_STEP_PS = 190;

   // Clock rate and the width of a sampled data word.
   localparam int CLK_PERIOD_PS = 4000;
   localparam int DATA_W        = 16;

   // Stored register contents.
   typedef struct packed {
      logic [4:0] dly_code;
      logic [3:0] margin_code;
      logic       lvds_sel;
      logic       invert;
      logic       dly_en;
      logic       auto_mode;
      logic       set_high;
      logic       polarity;
   } dct_cfg_t;

   // Control port request.
   typedef struct packed {
      logic        wr_en;
      logic        rd_en;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } dct_req_t;

endpackage : dct_pkg

// >>> design/dct_sync.sv
// Two-stage synchroniser with a third stage for edge finding.
// Assumes the inputs are asynchronous to clock; only the second
// stage and later are read by logic.
`timescale 1ns/1ps
module dct_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input  wire logic             clock,
   input  wire logic             rst_b,
   // Asynchronous input and synchronised views.
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_q,
   output logic      [WIDTH-1:0] prev_q
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

endmodule : dct_sync

// >>> design/dct_ctrl.sv
// Data port clock timing control: the register at control address
// 0x02, the output data clock path, sync pad selection and slave mode
// sampling on the external data clock input.
// Assumes the serial control core presents requests on clock, and the
// adjacent registers supply slave mode, pin enable and interpolation.
//
// Notes on behaviour
// - Five-bit output clock delay code, upper bits.
// - Four-bit timing margin delay code.
// - Margin delay grows with code value.
// - Select zero: sync pads carry multichip sync.
// - Select one: sync pads carry data clock.
// - Invert bit flips output data clock phase.
// - Delay enable zero: bypass, input sync off.
// - Delay enable one: delay cell, sync on.
// - Mode bit: manual or automatic optimization.
// - Polarity picks falling or rising sample edge.
// - Polarity matters only in slave mode.
// - Bit zero reserved, no function.
// - Two-byte register at address 0x02.
// - Slave mode at 4x or 8x interpolation turns pin into clock input.
// - Pin enable bit gates the output driver.
`timescale 1ns/1ps
module dct_ctrl (
   // Clock and reset.
   input  wire logic                      clock,
   input  wire logic                      rst_b,
   // Serial control port request and read data.
   input  wire dct_pkg::dct_req_t         req,
   output logic [15:0]                    rdata_q,
   output logic                           rvalid_q,
   // Neighbouring register fields.
   input  wire logic                      slave_mode_en,
   input  wire logic                      dclk_pin_en,
   input  wire logic [1:0]                interp_factor,
   // Internal clocks and multichip sync signal.
   input  wire logic                      smp_clk_lvl,
   input  wire logic                      mcs_sync,
   // Data clock pin, two-way.
   input  wire logic                      dclk_pin_in,
   output logic                           dclk_pin_out_q,
   output logic                           dclk_pin_oe_q,
   // Sync output pads.
   output logic                           sync_pad_p_q,
   output logic                           sync_pad_n_q,
   // Input data port.
   input  wire logic [dct_pkg::DATA_W-1:0] data_pins,
   output logic [dct_pkg::DATA_W-1:0]     data_word_q,
   output logic                           data_valid_q,
   // Analog delay cell controls.
   output logic [4:0]                     dly_code_q,
   output logic                           dly_path_q,
   output logic [3:0]                     margin_code_q,
   output logic                           in_sync_active_q,
   output logic                           auto_mode_q
);

   function automatic logic hit(input logic [7:0] addr);
      hit = (addr == dct_pkg::ADDR_DATA_PORT_CLOCK_TIMING);
   endfunction : hit

   dct_pkg::dct_cfg_t cfg_q;
   dct_pkg::dct_cfg_t cfg_d;
   logic              smp_prev_q;

   wire logic [15:0] wd = req.wdata;
   wire logic        wr_hit = req.wr_en && hit(req.addr);
   wire logic        rd_hit = req.rd_en && hit(req.addr);

   // bit zero is dropped, so it has no function.
   always_comb begin
      cfg_d = cfg_q;
      if (wr_hit) begin
         cfg_d.dly_code    = wd[dct_pkg::DLY_MSB:dct_pkg::DLY_LSB];
         cfg_d.margin_code = wd[dct_pkg::MARGIN_MSB:dct_pkg::MARGIN_LSB];
         cfg_d.lvds_sel    = wd[dct_pkg::LVDS_SEL];
         cfg_d.invert      = wd[dct_pkg::INVERT];
         cfg_d.dly_en      = wd[dct_pkg::DLY_EN];
         cfg_d.auto_mode   = wd[dct_pkg::AUTO_MODE];
         // stored as written; software keeps it high.
         cfg_d.set_high    = wd[dct_pkg::SET_HIGH];
         cfg_d.polarity    = wd[dct_pkg::POLARITY];
      end
   end

   wire logic [15:0] rd_word = {cfg_q.dly_code, cfg_q.margin_code,
                                cfg_q.lvds_sel, cfg_q.invert,
                                cfg_q.dly_en, cfg_q.auto_mode,
                                cfg_q.set_high, cfg_q.polarity, 1'b0};

   // Slave mode is honoured only at 4x or 8x interpolation, because
   // slower rates leave too little margin on the external clock.
   // slave mode qualification.
   wire logic slave_eff = slave_mode_en &&
                          (interp_factor == dct_pkg::INTERP_4X ||
                           interp_factor == dct_pkg::INTERP_8X);

   wire logic dclk_lvl = cfg_q.invert ? ~smp_clk_lvl : smp_clk_lvl;

   // driver enable; released in slave mode.
   wire logic pin_oe = dclk_pin_en && !slave_eff;

   // multichip sync by default; data clock when selected.
   wire logic pad_src = cfg_q.lvds_sel ? dclk_lvl : mcs_sync;

   // External clock and data pass two stages before use.
   logic                        ext_clk_s;
   logic                        ext_clk_p;
   logic [dct_pkg::DATA_W-1:0]  data_s;

   dct_sync #(.WIDTH(1)) u_clk_sync (
      .clock    (clock),
      .rst_b    (rst_b),
      .async_in (dclk_pin_in),
      .sync_q   (ext_clk_s),
      .prev_q   (ext_clk_p)
   );

   dct_sync #(.WIDTH(dct_pkg::DATA_W)) u_data_sync (
      .clock    (clock),
      .rst_b    (rst_b),
      .async_in (data_pins),
      .sync_q   (data_s),
      .prev_q   ()
   );

   wire logic ext_rise = ext_clk_s && !ext_clk_p;
   wire logic ext_fall = !ext_clk_s && ext_clk_p;
   wire logic int_rise = smp_clk_lvl && !smp_prev_q;

   // edge choice; used only in slave mode.
   wire logic ext_edge = cfg_q.polarity ? ext_rise : ext_fall;
   wire logic take     = slave_eff ? ext_edge : int_rise;

   // bypass forces zero delay; routes through cell.
   wire logic [4:0] dly_code_d = cfg_q.dly_en ? cfg_q.dly_code : 5'h00;

   // Register storage.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q <= dct_pkg::dct_cfg_t'(dct_pkg::RESET_DATA_PORT_CLOCK_TIMING
                                      [15:1]);
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // Read answer, one cycle after the request.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q  <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rd_hit ? rd_word : 16'h0000;
         rvalid_q <= req.rd_en;
      end
   end

   // Clock pin and sync pads.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dclk_pin_out_q <= 1'b0;
         dclk_pin_oe_q  <= 1'b0;
         sync_pad_p_q   <= 1'b0;
         sync_pad_n_q   <= 1'b1;
      end else begin
         dclk_pin_out_q <= dclk_lvl;
         dclk_pin_oe_q  <= pin_oe;
         sync_pad_p_q   <= pad_src;
         sync_pad_n_q   <= ~pad_src;
      end
   end

   // Data capture on the selected edge.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         smp_prev_q   <= 1'b0;
         data_word_q  <= '0;
         data_valid_q <= 1'b0;
      end else begin
         smp_prev_q   <= smp_clk_lvl;
         data_valid_q <= take;
         if (take) begin
            data_word_q <= data_s;
         end
      end
   end

   // Delay cell controls.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dly_code_q       <= 5'h00;
         dly_path_q       <= 1'b0;
         margin_code_q    <= 4'h0;
         in_sync_active_q <= 1'b0;
         auto_mode_q      <= 1'b0;
      end else begin
         dly_code_q       <= dly_code_d;
         dly_path_q       <= cfg_q.dly_en;
         margin_code_q    <= cfg_q.margin_code;
         in_sync_active_q <= cfg_q.dly_en;
         auto_mode_q      <= cfg_q.auto_mode;
      end
   end

endmodule : dct_ctrl

// >>> test/dct_chk.sv
// Port assertions for the data port clock timing control.
// Assumes a bind into dct_ctrl; one clock domain.
`timescale 1ns/1ps
module dct_chk (
   // Clock, reset, control port.
   input logic              clock,
   input logic              rst_b,
   input dct_pkg::dct_req_t req,
   input logic [15:0]       rdata_q,
   input logic              rvalid_q,
   // Neighbour fields and multichip sync.
   input logic              slave_mode_en,
   input logic              dclk_pin_en,
   input logic [1:0]        interp_factor,
   input logic              mcs_sync,
   // Watched outputs.
   input logic              dclk_pin_out_q,
   input logic              dclk_pin_oe_q,
   input logic              sync_pad_p_q,
   input logic              sync_pad_n_q,
   input logic [15:0]       data_word_q,
   input logic              data_valid_q,
   input logic [4:0]        dly_code_q,
   input logic              dly_path_q,
   input logic [3:0]        margin_code_q,
   input logic              in_sync_active_q,
   input logic              auto_mode_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire hit = req.addr == dct_pkg::ADDR_DATA_PORT_CLOCK_TIMING;
   wire wr  = req.wr_en && hit;
   read_ans_a: assert property (req.rd_en |=> rvalid_q)
      else $error("read not answered");
   unmapped_read_a: assert property (req.rd_en && !hit |=> !rdata_q)
      else $error("unmapped read not zero");
   rsv_bit_a: assert property (rvalid_q |-> !rdata_q[0])
      else $error("reserved bit read one");
   pin_oe_a: assert property ($past(rst_b) |-> dclk_pin_oe_q ==
      $past(dclk_pin_en && !(slave_mode_en && interp_factor[1])))
      else $error("pin enable wrong");
   pad_pair_a: assert property (sync_pad_n_q != sync_pad_p_q)
      else $error("sync pads not complementary");
   pad_source_a: assert property (sync_pad_p_q == $past(mcs_sync) ||
      sync_pad_p_q == dclk_pin_out_q) else $error("sync pad source wrong");
   bypass_path_a: assert property (in_sync_active_q == dly_path_q &&
      (dly_path_q || !dly_code_q)) else $error("bypass wrong");
   field_apply_a: assert property (wr |-> ##2
      {margin_code_q, dly_path_q, auto_mode_q} ==
      {$past(req.wdata[10:7], 2), $past(req.wdata[4:3], 2)})
      else $error("fields not applied");
   dly_code_a: assert property (wr && req.wdata[4] |-> ##2
      dly_code_q == $past(req.wdata[15:11], 2)) else $error("delay code");
   valid_pulse_a: assert property (data_valid_q |=> !data_valid_q)
      else $error("valid not a pulse");
   word_hold_a: assert property (!$stable(data_word_q) |-> data_valid_q)
      else $error("word changed without capture");
   cover property (wr && req.wdata[4]);
   cover property (data_valid_q && slave_mode_en);
   cover property (req.rd_en && !hit);
endmodule : dct_chk

// >>> test/dct_src.sv
// Data source model on the input data port.
// Assumes the bench calls send; its link clock idles low outside frames.
`timescale 1ns/1ps
module dct_src (
   // Link clock and data toward the block.
   output logic        dclk,
   output logic [15:0] data
);
   initial begin
      dclk = 1'b0;
      data = 16'h0000;
   end
   // One word per clock edge; after the frame the bus shows the inverse
   // so that a stale value is never taken for a held one.
   task automatic send(input logic [15:0] w1, input logic [15:0] w2);
      data = w1;
      #62.5 dclk = 1'b1;
      #31 data = w2;
      #31.5 dclk = 1'b0;
      #31 data = ~w2;
      #31.5;
   endtask : send
endmodule : dct_src

// >>> test/tb_data_clock_timing_control.sv
// Self-checking bench for the data port clock timing control.
// Assumes dct_ctrl, dct_chk and dct_src are compiled before it.
`timescale 1ns/1ps
module tb_data_clock_timing_control;
   logic              clock = 1'b0;
   logic              rst_b = 1'b0;
   dct_pkg::dct_req_t req = '0;
   logic              slave_mode_en = 1'b0;
   logic              dclk_pin_en = 1'b1;
   logic [1:0]        interp_factor = 2'h0;
   logic              smp_clk_lvl = 1'b0;
   logic              mcs_sync = 1'b0;
   logic              dclk_pin_in, rvalid_q, dclk_pin_out_q, dclk_pin_oe_q;
   logic              sync_pad_p_q, sync_pad_n_q, data_valid_q, dly_path_q;
   logic              in_sync_active_q, auto_mode_q;
   logic [15:0]       data_pins, rdata_q, data_word_q, w1, w2;
   logic [15:0]       mdl = dct_pkg::RESET_DATA_PORT_CLOCK_TIMING;
   logic [4:0]        dly_code_q;
   logic [3:0]        margin_code_q;
   logic [15:0]       rq[$], dq[$];
   int                n_fail = 0, checks_done = 0, cyc = 0;

   always #2 clock = ~clock;

   dct_ctrl u_dut (
      .clock(clock), .rst_b(rst_b), .req(req), .rdata_q(rdata_q),
      .rvalid_q(rvalid_q), .slave_mode_en(slave_mode_en),
      .dclk_pin_en(dclk_pin_en), .interp_factor(interp_factor),
      .smp_clk_lvl(smp_clk_lvl), .mcs_sync(mcs_sync),
      .dclk_pin_in(dclk_pin_in), .dclk_pin_out_q(dclk_pin_out_q),
      .dclk_pin_oe_q(dclk_pin_oe_q), .sync_pad_p_q(sync_pad_p_q),
      .sync_pad_n_q(sync_pad_n_q), .data_pins(data_pins),
      .data_word_q(data_word_q), .data_valid_q(data_valid_q),
      .dly_code_q(dly_code_q), .dly_path_q(dly_path_q),
      .margin_code_q(margin_code_q), .in_sync_active_q(in_sync_active_q),
      .auto_mode_q(auto_mode_q)
   );
   dct_src u_src (.dclk(dclk_pin_in), .data(data_pins));

   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask : cmp

   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
      if (!w)
         rq.push_back(a == 8'h02 ? mdl : 16'h0000);
      else if (a == 8'h02)
         mdl = d & 16'hFFFE;
      req = '{w, !w, a, d};
      @(posedge clock) #1 req = '0;
      // An idle edge keeps back-to-back calls from driving req twice.
      @(posedge clock) #1;
   endtask : acc

   task automatic waitc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : waitc

   task automatic finish_test();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   // Results are settled at the falling edge.
   always @(negedge clock) begin
      if (rvalid_q === 1'b1 && rq.size() == 0)
         cmp(16'h0000, 16'hFFFF);
      else if (rvalid_q === 1'b1)
         cmp(rdata_q, rq.pop_front());
      if (data_valid_q === 1'b1 && dq.size() == 0)
         cmp(16'h0000, 16'hFFFF);
      else if (data_valid_q === 1'b1)
         cmp(data_word_q, dq.pop_front());
   end

   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         finish_test();
      end
   end

   initial begin
      void'($urandom(32'h6326));
      repeat (8) @(posedge clock);
      #1 rst_b = 1'b1;
      acc(1'b0, 8'h02, 16'h0000);
      acc(1'b1, 8'h05, 16'hFFFF);
      acc(1'b0, 8'h05, 16'h0000);
      acc(1'b0, 8'h02, 16'h0000);
      $display("test reset_map done");
      for (int i = 0; i < 8; i++) begin
         w1 = 16'($urandom) | 16'h0005;
         slave_mode_en = 1'($urandom);
         dclk_pin_en = 1'($urandom);
         interp_factor = 2'($urandom);
         acc(1'b1, 8'h02, w1);
         acc(1'b0, 8'h02, 16'h0000);
      end
      slave_mode_en = 1'b0;
      $display("test random_rw done");
      for (int i = 0; i < 4; i++) begin
         mcs_sync = 1'($urandom);
         acc(1'b1, 8'h02, {5'h15, 4'h9, i[1], i[0], i[1] ^ i[0], 4'h4});
         waitc(3);
         cmp(16'(dclk_pin_out_q), 16'(i[0]));
         cmp(16'(sync_pad_p_q), 16'(i[1] ? i[0] : mcs_sync));
         cmp(16'(dly_code_q), i[1] ^ i[0] ? 16'h0015 : 16'h0000);
      end
      $display("test pads_invert done");
      slave_mode_en = 1'b1;
      for (int i = 0; i < 4; i++) begin
         interp_factor = {1'b1, i[0]};
         acc(1'b1, 8'h02, {14'h0001, i[1], 1'b0});
         w1 = 16'($urandom);
         w2 = 16'($urandom);
         dq.push_back(i[1] ? w1 : w2);
         waitc(3);
         cmp(16'(dclk_pin_oe_q), 16'h0000);
         u_src.send(w1, w2);
         waitc(6);
      end
      interp_factor = 2'h1;
      waitc(3);
      u_src.send(w1, w2);
      waitc(6);
      slave_mode_en = 1'b0;
      waitc(3);
      $display("test slave_capture done");
      dq.push_back(data_pins);
      smp_clk_lvl = 1'b1;
      waitc(4);
      smp_clk_lvl = 1'b0;
      waitc(6);
      $display("test master_capture done");
      n_fail += rq.size() + dq.size();
      finish_test();
   end
endmodule : tb_data_clock_timing_control

bind dct_ctrl dct_chk u_chk (
   .clock(clock), .rst_b(rst_b), .req(req), .rdata_q(rdata_q),
   .rvalid_q(rvalid_q), .slave_mode_en(slave_mode_en),
   .dclk_pin_en(dclk_pin_en), .interp_factor(interp_factor),
   .mcs_sync(mcs_sync), .dclk_pin_out_q(dclk_pin_out_q),
   .dclk_pin_oe_q(dclk_pin_oe_q), .sync_pad_p_q(sync_pad_p_q),
   .sync_pad_n_q(sync_pad_n_q), .data_word_q(data_word_q),
   .data_valid_q(data_valid_q), .dly_code_q(dly_code_q),
   .dly_path_q(dly_path_q), .margin_code_q(margin_code_q),
   .in_sync_active_q(in_sync_active_q), .auto_mode_q(auto_mode_q)
);
